// ===== hw/port_pkg.sv
/*
 Constants for the eight-bit shared-function I/O port: register byte offsets,
 field positions, reset values and the depth of the pin synchroniser.
 Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
package port_pkg;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] off_port_direction = 8'h00;
   localparam logic [7:0] off_port_output_latch = 8'h04;
   localparam logic [7:0] off_pullup_control = 8'h08;
   localparam logic [7:0] off_pin_function = 8'h0c;
   localparam logic [7:0] off_pin_level = 8'h10;

   // ==========================================================
   // pin_function register fields
   localparam int fld_aux_timer_output_select_lo = 0;
   localparam int fld_aux_timer_output_select_w = 4;
   localparam int fld_compare_b_out_enable = 4;
   localparam int fld_clamp_out_enable = 5;
   localparam int fld_compare_a_out_enable = 6;
   localparam int fld_vsync_out_enable = 7;
   localparam int fld_ext_int7_enable = 8;
   localparam int fld_ext_int6_enable = 9;
   localparam int fld_keysense_mask6 = 10;
   localparam int pin_function_w = 11;

   // ==========================================================
   // reset values
   localparam logic [7:0] rst_port_direction = 8'h00;
   localparam logic [7:0] rst_port_output_latch = 8'h00;
   localparam logic [7:0] rst_pullup_control = 8'h00;
   localparam logic [10:0] rst_pin_function = 11'h000;

   // ==========================================================
   // pin numbers of the shared functions
   localparam int pin_aux_timer = 7;
   localparam int pin_compare_b = 6;
   localparam int pin_capture_d = 5;
   localparam int pin_clamp = 4;
   localparam int pin_capture_b = 3;
   localparam int pin_capture_a = 2;
   localparam int pin_vsync = 1;

   // synchroniser depth in flip-flops
   localparam int sync_stages = 2;

endpackage

// ===== hw/shared_port.sv
/*
 Eight-bit general-purpose I/O port with per-pin direction, output latch and
 pull-up control, pins 7 to 1 shared with timer outputs and peripheral inputs.
 Registers: direction (write-only, reads zero), output latch (reads the latch
 on output pins and the synchronised level on input pins), pull-up control,
 pin function selects, and a read-only view of the synchronised pin levels.
 Assumes a single AHB-Lite master, 32-bit single word transfers, and pin
 inputs that may be asynchronous to clk_sys_in.
 Assumes the peripheral output levels already belong to the clk_sys_in domain.
*/
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps

module shared_port
#(
   parameter int pin_count = 8
)
(
   input wire logic clk_sys_in, // system clock, 10 MHz
   input wire logic rst_n_in, // synchronous reset, active low
   // ahb-lite slave
   input wire logic hsel_in, // slave select
   input wire logic [7:0] haddr_in, // byte address
   input wire logic [1:0] htrans_in, // transfer type
   input wire logic hwrite_in, // 1 = write
   input wire logic [2:0] hsize_in, // transfer size
   input wire logic [31:0] hwdata_in, // write data
   input wire logic hready_in, // bus ready
   output logic [31:0] hrdata_out, // read data
   output logic hreadyout_out, // slave ready
   output logic hresp_out, // always okay
   // pads
   input wire logic [pin_count-1:0] pin_in, // pad levels
   output logic [pin_count-1:0] pin_out, // pad drive value
   output logic [pin_count-1:0] pin_oe_out, // pad drive enable
   output logic [pin_count-1:0] pullup_en_out, // pad pull-up enable
   // peripheral outputs that can take over pins
   input wire logic aux_timer_compare_out_in, // auxiliary timer compare
   input wire logic compare_b_out_in, // free-running timer compare b
   input wire logic clamp_out_in, // timer-connection clamp
   input wire logic vertical_sync_out_in, // timer-connection vsync
   input wire logic compare_a_out_in, // free-running timer compare a
   // synchronised pin levels to peripherals
   output logic [pin_count-1:0] keysense_in_out, // key-sense inputs
   output logic [pin_count-1:0] comparator_in_out, // comparator inputs
   output logic ext_int7_out, // external interrupt 7 input
   output logic ext_int6_out, // external interrupt 6 input
   output logic capture_d_in_out, // capture d input
   output logic capture_c_in_out, // capture c input
   output logic capture_b_in_out, // capture b input
   output logic vertical_feedback_in_out, // vertical feedback input
   output logic capture_a_in_out, // capture a input
   output logic second_timer_clock_in_out, // second timer clock input
   output logic vertical_sync_in_out // vertical sync input
);

   // ==========================================================
   // declarations
   logic [pin_count-1:0] port_direction;
   logic [pin_count-1:0] port_output_latch;
   logic [pin_count-1:0] pullup_control;
   logic [port_pkg::pin_function_w-1:0] pin_function;
   logic [pin_count-1:0] next_port_direction;
   logic [pin_count-1:0] next_port_output_latch;
   logic [pin_count-1:0] next_pullup_control;
   logic [port_pkg::pin_function_w-1:0] next_pin_function;

   logic wr_pending;
   logic [7:0] wr_addr;
   logic next_wr_pending;
   logic [7:0] next_wr_addr;
   logic [31:0] next_hrdata;

   logic [pin_count-1:0] sync_meta;
   logic [pin_count-1:0] pin_level;
   logic [pin_count-1:0] next_sync_meta;
   logic [pin_count-1:0] next_pin_level;

   logic next_ext_int7;
   logic next_ext_int6;

   logic [pin_count-1:0] periph_drive;
   logic [pin_count-1:0] periph_value;
   logic [3:0] aux_timer_output_select;
   logic addr_phase;

   assign aux_timer_output_select =
      pin_function[port_pkg::fld_aux_timer_output_select_lo +:
                   port_pkg::fld_aux_timer_output_select_w];

   // ==========================================================
   // bus slave: address phase capture
   // zero wait states, so hready_in qualifies every accepted address phase
   assign addr_phase = hsel_in && htrans_in[1] && hready_in;
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;
   // hsize_in is not decoded: every register is one word and only word
   // transfers are expected, so a narrower write still updates the whole field

   always_comb
   begin
      next_wr_pending = addr_phase && hwrite_in;
      next_wr_addr = wr_addr;
      if (addr_phase)
      begin
         next_wr_addr = haddr_in;
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         wr_pending <= 1'b0;
         wr_addr <= 8'h00;
      end
      else
      begin
         wr_pending <= next_wr_pending;
         wr_addr <= next_wr_addr;
      end
   end

   // ==========================================================
   // register file: writes land at the end of the data phase
   // the address is kept from the address phase, since haddr_in may already
   // carry the next transfer while this data phase is under way
   always_comb
   begin
      next_port_direction = port_direction;
      next_port_output_latch = port_output_latch;
      next_pullup_control = pullup_control;
      next_pin_function = pin_function;
      if (wr_pending)
      begin
         unique case (wr_addr)
            port_pkg::off_port_direction:
            begin
               next_port_direction = hwdata_in[pin_count-1:0];
            end
            port_pkg::off_port_output_latch:
            begin
               next_port_output_latch = hwdata_in[pin_count-1:0];
            end
            port_pkg::off_pullup_control:
            begin
               next_pullup_control = hwdata_in[pin_count-1:0];
            end
            port_pkg::off_pin_function:
            begin
               next_pin_function = hwdata_in[port_pkg::pin_function_w-1:0];
            end
            default:
            begin
               // unmapped or read-only offset: write ignored
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         port_direction <= port_pkg::rst_port_direction;
         port_output_latch <= port_pkg::rst_port_output_latch;
         pullup_control <= port_pkg::rst_pullup_control;
         pin_function <= port_pkg::rst_pin_function;
      end
      else
      begin
         port_direction <= next_port_direction;
         port_output_latch <= next_port_output_latch;
         pullup_control <= next_pullup_control;
         pin_function <= next_pin_function;
      end
   end

   // ==========================================================
   // read data
   // the mux looks at next_ values so a read right behind a write sees it
   // input pins read through the synchroniser, so a pad change shows two cycles later
   always_comb
   begin
      next_hrdata = 32'h0000_0000;
      if (addr_phase && !hwrite_in)
      begin
         unique case (haddr_in)
            port_pkg::off_port_output_latch:
            begin
               next_hrdata[pin_count-1:0] =
                  (next_port_output_latch & next_port_direction) |
                  (pin_level & ~next_port_direction);
            end
            port_pkg::off_pullup_control:
            begin
               next_hrdata[pin_count-1:0] = next_pullup_control;
            end
            port_pkg::off_pin_function:
            begin
               next_hrdata[port_pkg::pin_function_w-1:0] = next_pin_function;
            end
            port_pkg::off_pin_level:
            begin
               next_hrdata[pin_count-1:0] = pin_level;
            end
            default:
            begin
               // direction register is write-only; unmapped reads give zero
               next_hrdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         hrdata_out <= 32'h0000_0000;
      end
      else
      begin
         hrdata_out <= next_hrdata;
      end
   end

   // ==========================================================
   // pin function selection; no mode input exists, so it is mode-independent
   // a takeover ignores the direction bit, so software can switch a timer
   // output on and off without touching the direction register
   always_comb
   begin
      periph_drive = '0;
      periph_value = '0;
      periph_drive[port_pkg::pin_aux_timer] = |aux_timer_output_select;
      periph_value[port_pkg::pin_aux_timer] = aux_timer_compare_out_in;
      periph_drive[port_pkg::pin_compare_b] =
         pin_function[port_pkg::fld_compare_b_out_enable];
      periph_value[port_pkg::pin_compare_b] = compare_b_out_in;
      periph_drive[port_pkg::pin_clamp] =
         pin_function[port_pkg::fld_clamp_out_enable];
      periph_value[port_pkg::pin_clamp] = clamp_out_in;
      // vsync out outranks compare a on pin 1
      if (pin_function[port_pkg::fld_vsync_out_enable])
      begin
         periph_drive[port_pkg::pin_vsync] = 1'b1;
         periph_value[port_pkg::pin_vsync] = vertical_sync_out_in;
      end
      else if (pin_function[port_pkg::fld_compare_a_out_enable])
      begin
         periph_drive[port_pkg::pin_vsync] = 1'b1;
         periph_value[port_pkg::pin_vsync] = compare_a_out_in;
      end
   end

   // pins 5, 3, 2 and 0 have no output takeover and follow direction only
   assign pin_oe_out = periph_drive | port_direction;
   assign pin_out = (periph_drive & periph_value) |
                    (~periph_drive & port_direction & port_output_latch);
   // the pull-up is dropped under any drive so it never fights an output
   assign pullup_en_out = pullup_control & ~port_direction & ~periph_drive;

   // ==========================================================
   // input synchroniser and peripheral input routing
   // only the second flop is read anywhere; the first may go metastable
   // interrupt inputs add one more flop, so they trail key-sense by a cycle
   always_comb
   begin
      next_sync_meta = pin_in;
      next_pin_level = sync_meta;
      next_ext_int7 = pin_level[port_pkg::pin_aux_timer] &
                      pin_function[port_pkg::fld_ext_int7_enable];
      next_ext_int6 = pin_level[port_pkg::pin_compare_b] &
                      pin_function[port_pkg::fld_ext_int6_enable] &
                      ~pin_function[port_pkg::fld_keysense_mask6];
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         sync_meta <= '0;
         pin_level <= '0;
         ext_int7_out <= 1'b0;
         ext_int6_out <= 1'b0;
      end
      else
      begin
         sync_meta <= next_sync_meta;
         pin_level <= next_pin_level;
         ext_int7_out <= next_ext_int7;
         ext_int6_out <= next_ext_int6;
      end
   end

   // key-sense and comparator always observe every pin, even while driven
   assign keysense_in_out = pin_level;
   assign comparator_in_out = pin_level;
   assign capture_d_in_out = pin_level[port_pkg::pin_capture_d];
   assign capture_c_in_out = pin_level[port_pkg::pin_clamp];
   assign capture_b_in_out = pin_level[port_pkg::pin_capture_b];
   assign vertical_feedback_in_out = pin_level[port_pkg::pin_capture_b];
   assign capture_a_in_out = pin_level[port_pkg::pin_capture_a];
   assign second_timer_clock_in_out = pin_level[port_pkg::pin_capture_a];
   assign vertical_sync_in_out = pin_level[port_pkg::pin_capture_a];

endmodule // shared_port

// ===== sim/eight_bit_port_with_pin_sharing_test.sv
/*
 Self-checking bench for shared_port with a pad board model.
 Assumes the single AHB-Lite master below and a 10 MHz clock.
*/
`timescale 1ns/1ps

module eight_bit_port_with_pin_sharing_test;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic [7:0] pin_in, pin_out, pin_oe, pullup_en, ks, ext_en, ext_val, dir, lat, pu;
   logic [4:0] per = 5'h00;
   logic int7, int6;
   logic [10:0] fn;
   int fails = 0;
   int checks = 0;
   int pin_t[6] = '{7, 7, 6, 4, 1, 1};
   int src_t[6] = '{4, 4, 3, 2, 0, 1};
   logic [10:0] fn_t[6] = '{11'h001, 11'h008, 11'h010, 11'h020, 11'h040, 11'h0c0};
   logic [10:0] fn_int[4] = '{11'h100, 11'h200, 11'h600, 11'h000};

   shared_port #(.pin_count(8)) i_dut (.clk_sys_in(clk_sys), .rst_n_in(rst_n),
      .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hreadyout), .hrdata_out(hrdata),
      .hreadyout_out(hreadyout), .hresp_out(), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_out(pin_oe), .pullup_en_out(pullup_en), .aux_timer_compare_out_in(per[4]),
      .compare_b_out_in(per[3]), .clamp_out_in(per[2]), .vertical_sync_out_in(per[1]),
      .compare_a_out_in(per[0]), .keysense_in_out(ks), .comparator_in_out(),
      .ext_int7_out(int7), .ext_int6_out(int6), .capture_d_in_out(), .capture_c_in_out(),
      .capture_b_in_out(), .vertical_feedback_in_out(), .capture_a_in_out(),
      .second_timer_clock_in_out(), .vertical_sync_in_out());

   pad_board i_pads (.clk_sys_in(clk_sys), .pin_out_in(pin_out), .pin_oe_in(pin_oe),
      .pullup_in(pullup_en), .ext_en_in(ext_en), .ext_val_in(ext_val), .pad_out(pin_in));

   initial
   begin
      forever #50 clk_sys = ~clk_sys;
   end

   // ======
   // helpers
   function automatic logic [31:0] exp_port(logic [7:0] l, logic [7:0] d, logic [7:0] e);
      return 32'((l & d) | (e & ~d));
   endfunction

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // called right after a rising edge; waits for hready at each phase
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] unused;
      bus(1'b1, a, d, unused);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] got;
      bus(1'b0, a, 32'h0, got);
      check(what, exp, got);
   endtask

   task automatic final_report();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (5000) @(posedge clk_sys);
      fails++;
      final_report();
   end

   // ======
   // main sequence
   initial
   begin
      ext_en = 8'hff;
      ext_val = 8'hff;
      void'($urandom(17471));
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      check("drive enable at reset", 32'h0, 32'(pin_oe));
      rd_chk(8'h08, 32'h0, "pull-up reset");
      rd_chk(8'h0c, 32'h0, "function reset");
      wr(8'h00, 32'hff);
      rd_chk(8'h04, 32'h0, "latch reset");
      rd_chk(8'h00, 32'h0, "direction read");
      $display("reset test done");
      repeat (24)
      begin
         dir = 8'($urandom);
         lat = 8'($urandom);
         pu = 8'($urandom);
         ext_val <= 8'($urandom);
         per <= 5'($urandom);
         wr(8'h00, 32'(dir));
         wr(8'h04, 32'(lat));
         wr(8'h08, 32'(pu));
         repeat (3) @(posedge clk_sys);
         check("drive enable", 32'(dir), 32'(pin_oe));
         check("drive value", 32'(lat & dir), 32'(pin_out & dir));
         check("pull-up enable", 32'(pu & ~dir), 32'(pullup_en));
         rd_chk(8'h04, exp_port(lat, dir, ext_val), "port read");
         rd_chk(8'h10, exp_port(lat, dir, ext_val), "level read");
         check("key-sense", exp_port(lat, dir, ext_val), 32'(ks));
      end
      ext_en <= 8'h00;
      wr(8'h00, 32'h0);
      wr(8'h08, 32'hff);
      repeat (3) @(posedge clk_sys);
      rd_chk(8'h04, 32'hff, "pulled-up read");
      $display("plain i/o test done");
      for (int k = 0; k < 6; k++)
      begin
         wr(8'h0c, 32'(fn_t[k]));
         for (int j = 0; j < 2; j++)
         begin
            per <= (j == 0) ? 5'($urandom) : ~per;
            @(posedge clk_sys);
            check("takeover enable", 32'h1, 32'(pin_oe[pin_t[k]]));
            check("takeover value", 32'(per[src_t[k]]), 32'(pin_out[pin_t[k]]));
            check("takeover pull-up", 32'h0, 32'(pullup_en[pin_t[k]]));
         end
      end
      $display("takeover test done");
      ext_en <= 8'hff;
      // second pass holds pins 7 and 6 low, so an enable alone must not fire
      for (int k = 0; k < 8; k++)
      begin
         fn = fn_int[k % 4];
         ext_val <= (k < 4) ? 8'hff : (8'($urandom) & 8'h3f);
         wr(8'h0c, 32'(fn));
         repeat (4) @(posedge clk_sys);
         check("interrupt 7", 32'(fn[8] & ext_val[7]), 32'(int7));
         check("interrupt 6", 32'(fn[9] & ~fn[10] & ext_val[6]), 32'(int6));
      end
      $display("interrupt test done");
      wr(8'h20, 32'hffffffff);
      rd_chk(8'h20, 32'h0, "unmapped read");
      wr(8'h00, 32'hff);
      rst_n <= 1'b0;
      @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rd_chk(8'h08, 32'h0, "pull-up after reset");
      check("drive after reset", 32'h0, 32'(pin_oe));
      $display("unmapped and reset test done");
      final_report();
   end
endmodule // eight_bit_port_with_pin_sharing_test

// ===== sim/pad_board.sv
/*
 Board model of the eight port pads: resolves each pad from the device drive,
 the pull-up and an optional board driver.
 Assumes the bench drives ext_en_in and ext_val_in off the clock edge.
*/
`timescale 1ns/1ps

module pad_board
(
   input wire logic clk_sys_in, // system clock
   input wire logic [7:0] pin_out_in, // device drive value
   input wire logic [7:0] pin_oe_in, // device drive enable
   input wire logic [7:0] pullup_in, // device pull-up enable
   input wire logic [7:0] ext_en_in, // board drives the pad
   input wire logic [7:0] ext_val_in, // board drive level
   output logic [7:0] pad_out // resolved pad level
);
   logic [7:0] float_bits = 8'h55;

   // a floating pad must never look like a steady level
   always @(posedge clk_sys_in)
      float_bits <= ~float_bits;

   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (pin_oe_in[i])
            pad_out[i] = pin_out_in[i];
         else if (ext_en_in[i])
            pad_out[i] = ext_val_in[i];
         else if (pullup_in[i])
            pad_out[i] = 1'b1;
         else
            pad_out[i] = float_bits[i];
      end
   end
endmodule // pad_board

// ===== sim/shared_port_properties.sv
/*
 Port-level checker for shared_port: bus answer, synchroniser, routing, pulls.
 Assumes binding into every shared_port instance.
*/
`timescale 1ns/1ps

module shared_port_checker
#(
   parameter int pin_count = 8
)
(
   input wire logic clk_sys_in, // clock
   input wire logic rst_n_in, // reset
   input wire logic hsel_in, // select
   input wire logic [7:0] haddr_in, // address
   input wire logic [1:0] htrans_in, // transfer
   input wire logic hwrite_in, // write
   input wire logic hready_in, // ready
   input wire logic [31:0] hrdata_out, // read data
   input wire logic hreadyout_out, // ready out
   input wire logic hresp_out, // response
   input wire logic [pin_count-1:0] pin_in, // pads
   input wire logic [pin_count-1:0] pin_out, // drive
   input wire logic [pin_count-1:0] pin_oe_out, // enable
   input wire logic [pin_count-1:0] pullup_en_out, // pull-up
   input wire logic [pin_count-1:0] keysense_in_out, // key-sense
   input wire logic [pin_count-1:0] comparator_in_out, // comparator
   input wire logic ext_int7_out, // int 7
   input wire logic ext_int6_out, // int 6
   input wire logic capture_d_in_out, // pin 5
   input wire logic capture_c_in_out, // pin 4
   input wire logic capture_b_in_out, // pin 3
   input wire logic vertical_feedback_in_out, // pin 3
   input wire logic capture_a_in_out, // pin 2
   input wire logic second_timer_clock_in_out, // pin 2
   input wire logic vertical_sync_in_out // pin 2
);
   default clocking @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n_in);

   logic take;
   logic [1:0] settle;
   logic [1:0] next_settle;
   logic [1:0] wr_dly;
   logic [1:0] next_wr_dly;

   assign take = hsel_in && htrans_in[1] && hready_in;

   // ======
   // helper: cycles since reset, and writes to direction or latch
   always_comb
   begin
      next_settle = settle;
      if (!rst_n_in)
         next_settle = 2'h0;
      else if (settle != 2'h3)
         next_settle = settle + 2'h1;
      next_wr_dly = {wr_dly[0], take && hwrite_in && (haddr_in == 8'h00 || haddr_in == 8'h04)};
   end

   always_ff @(posedge clk_sys_in)
   begin
      settle <= next_settle;
      wr_dly <= next_wr_dly;
   end

   // ======
   // assertions
   AST_BUS_OKAY: assert property (hreadyout_out && !hresp_out)
      else $error("slave not ready or response not okay");
   AST_UPPER_ZERO: assert property (hrdata_out[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   AST_DIR_READ_ZERO: assert property (take && !hwrite_in && haddr_in == 8'h00 |=> hrdata_out == 32'h0)
      else $error("direction read not zero");
   AST_SYNC_TWO: assert property (settle == 2'h3 |-> keysense_in_out == $past(pin_in, 2))
      else $error("key-sense not pin level two cycles back");
   AST_CMP_KEY: assert property (comparator_in_out == keysense_in_out)
      else $error("comparator inputs differ from key-sense");
   AST_ROUTE: assert property ({capture_d_in_out, capture_c_in_out, capture_b_in_out,
      vertical_feedback_in_out, capture_a_in_out, second_timer_clock_in_out, vertical_sync_in_out}
      == {keysense_in_out[5:3], keysense_in_out[3], {3{keysense_in_out[2]}}})
      else $error("peripheral input routing wrong");
   AST_PULLUP_OFF: assert property (!(|(pullup_en_out & pin_oe_out)))
      else $error("pull-up on a driven pin");
   AST_INT7_GATED: assert property (ext_int7_out |-> $past(keysense_in_out[7]))
      else $error("interrupt 7 without pin level");
   AST_INT6_GATED: assert property (ext_int6_out |-> $past(keysense_in_out[6]))
      else $error("interrupt 6 without pin level");
   AST_PLAIN_PINS: assert property (settle == 2'h3 && $changed({pin_oe_out[5], pin_out[5],
      pin_oe_out[3:2], pin_out[3:2]}) |-> wr_dly[1])
      else $error("plain pin changed without a register write");

   cover property (take && hwrite_in);
   cover property (ext_int7_out);
   cover property (pin_oe_out[7] && !pullup_en_out[7]);
endmodule // shared_port_checker

bind shared_port shared_port_checker #(.pin_count(pin_count)) i_checker (
   .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
   .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
   .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .pin_in(pin_in), .pin_out(pin_out),
   .pin_oe_out(pin_oe_out), .pullup_en_out(pullup_en_out), .keysense_in_out(keysense_in_out),
   .comparator_in_out(comparator_in_out), .ext_int7_out(ext_int7_out),
   .ext_int6_out(ext_int6_out), .capture_d_in_out(capture_d_in_out),
   .capture_c_in_out(capture_c_in_out), .capture_b_in_out(capture_b_in_out),
   .vertical_feedback_in_out(vertical_feedback_in_out), .capture_a_in_out(capture_a_in_out),
   .second_timer_clock_in_out(second_timer_clock_in_out),
   .vertical_sync_in_out(vertical_sync_in_out));
